// ===== acc_pkg.sv
// Constants and register map for the analog comparator control block.
// Function
// - Result bit is one when positive input exceeds negative input.
// - Mux enabled and converter off: channel select picks channel 0..7 as negative.
// - Mux disabled or converter on: dedicated negative pin used.
// - Bandgap select feeds reference to positive input, else positive pin.
// - Raw comparator output synchronized before the result bit, one to two cycles.
// - Flag set when an output change matches the chosen event mode.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Request only while flag, local enable and global enable all set.
// - Flag cleared automatically when the interrupt vector is entered.
// - Writing one to the flag clears it; zero leaves it.
// - Capture select routes output to timer capture front end, else none.
// - Disable bit powers the comparator off; zero restores power.
// - Digital-input-disable bit turns off pin buffer; port bit reads zero.
// - Mux enable at bit 6 lets converter mux pick negative input.
package acc_pkg;
  localparam logic [7:0] ADDR_CMP_CTRL    = 8'h30;
  localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h31;
  localparam logic [7:0] ADDR_DIG_DIS     = 8'h32;
  localparam int BIT_POWER_OFF  = 7;
  localparam int BIT_BANDGAP    = 6;
  localparam int BIT_RESULT     = 5;
  localparam int BIT_FLAG       = 4;
  localparam int BIT_IRQ_EN     = 3;
  localparam int BIT_CAPTURE    = 2;
  localparam int BIT_MODE_HI    = 1;
  localparam int BIT_MODE_LO    = 0;
  localparam int BIT_MUX_EN     = 6;
  localparam int BIT_NEG_DIG    = 1;
  localparam int BIT_POS_DIG    = 0;
  localparam logic [1:0] MODE_TOGGLE   = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL     = 2'h2;
  localparam logic [1:0] MODE_RISE     = 2'h3;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [2:0] NEG_SEL_PIN   = 3'h0;
  localparam logic [7:0] READ_ZERO     = 8'h00;
endpackage

// ===== acc_top.sv
// Digital control, event and routing logic around the analog comparator.
module acc_top
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       comparator_raw,
  input  wire logic       converter_enable,
  input  wire logic [2:0] channel_select,
  input  wire logic       global_irq_enable,
  input  wire logic       vector_taken,
  input  wire logic       pos_pin_digital_raw,
  input  wire logic       neg_pin_digital_raw,
  output logic            irq_request,
  output logic            capture_input,
  output logic            comparator_power_off,
  output logic            bandgap_select,
  output logic            neg_use_channel,
  output logic      [2:0] neg_channel,
  output logic            pos_pin_digital_off,
  output logic            neg_pin_digital_off,
  output logic            pos_pin_in,
  output logic            neg_pin_in
);
  logic [7:0] ctrl_r;
  logic [7:0] convb_r;
  logic [7:0] dig_r;
  logic       flag_r;
  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic       ps1_r;
  logic       ps2_r;
  logic       ns1_r;
  logic       ns2_r;
  logic       event_hit;
  logic       mux_sel;

  // True when a write strobe addresses the given register.
  function automatic logic is_wr(input logic [7:0] a, input logic [7:0] reg_a,
                                 input logic w);
    return w && (a == reg_a);
  endfunction

  // Matches a change of the synchronized result against the event mode.
  function automatic logic event_match(input logic [1:0] mode,
                                       input logic       now_v,
                                       input logic       old_v);
    logic hit;
    hit = 1'b0;
    case (mode)
      acc_pkg::MODE_TOGGLE:   hit = now_v ^ old_v;
      acc_pkg::MODE_FALL:     hit = old_v & ~now_v;
      acc_pkg::MODE_RISE:     hit = now_v & ~old_v;
      acc_pkg::MODE_RESERVED: hit = 1'b0;
      default:                hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Builds the control and status byte: the live result and flag take the
  // place of whatever software last wrote to those two positions.
  function automatic logic [7:0] status_byte(input logic [7:0] ctrl,
                                             input logic       res,
                                             input logic       flg);
    logic [7:0] v;
    v = ctrl;
    v[acc_pkg::BIT_RESULT] = res;
    v[acc_pkg::BIT_FLAG]   = flg;
    return v;
  endfunction

  // The raw comparator output is asynchronous; two flops tame metastability.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      sync1_r <= 1'b0;
    else
      sync1_r <= comparator_raw;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      sync2_r <= 1'b0;
    else
      sync2_r <= sync1_r;
  end

  // Previous synchronized value, the reference for edge detection.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      prev_r <= 1'b0;
    else
      prev_r <= sync2_r;
  end

  always_comb
  begin
    event_hit = event_match(
      ctrl_r[acc_pkg::BIT_MODE_HI:acc_pkg::BIT_MODE_LO], sync2_r, prev_r);
  end

  // Control bits; the whole written byte is stored, result and flag positions too.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctrl_r <= acc_pkg::RESET_BYTE;
    else if (is_wr(addr, acc_pkg::ADDR_CMP_CTRL, wr))
      ctrl_r <= wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      convb_r <= acc_pkg::RESET_BYTE;
    else if (is_wr(addr, acc_pkg::ADDR_CONV_CTRL_B, wr))
      convb_r <= wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      dig_r <= acc_pkg::RESET_BYTE;
    else if (is_wr(addr, acc_pkg::ADDR_DIG_DIS, wr))
      dig_r <= wdata;
  end

  // An event in the same cycle as a clear wins.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      flag_r <= 1'b0;
    else if (event_hit)
      flag_r <= 1'b1;
    else if (vector_taken)
      flag_r <= 1'b0;
    else if (is_wr(addr, acc_pkg::ADDR_CMP_CTRL, wr) &&
             wdata[acc_pkg::BIT_FLAG])
      flag_r <= 1'b0;
  end

  always_comb
  begin
    mux_sel = convb_r[acc_pkg::BIT_MUX_EN] & ~converter_enable;
  end

  // Pin digital inputs are asynchronous: each passes two flops before use.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ps1_r <= 1'b0;
    else
      ps1_r <= pos_pin_digital_raw;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ps2_r <= 1'b0;
    else
      ps2_r <= ps1_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ns1_r <= 1'b0;
    else
      ns1_r <= neg_pin_digital_raw;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ns2_r <= 1'b0;
    else
      ns2_r <= ns1_r;
  end

  // The request drops on the edge that samples the vector taken, the same edge that clears the flag, so the handler
  // does not see its own request once more while the flag clears.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      irq_request <= 1'b0;
    else
      irq_request <= flag_r & ctrl_r[acc_pkg::BIT_IRQ_EN] &
                     global_irq_enable & ~vector_taken;
  end

  // The timer sees the synchronized result only while routing is enabled.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      capture_input <= 1'b0;
    else
      capture_input <= ctrl_r[acc_pkg::BIT_CAPTURE] & sync2_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      comparator_power_off <= 1'b0;
    else
      comparator_power_off <= ctrl_r[acc_pkg::BIT_POWER_OFF];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      bandgap_select <= 1'b0;
    else
      bandgap_select <= ctrl_r[acc_pkg::BIT_BANDGAP];
  end

  // Negative input steering: the converter mux only while the converter is
  // off; otherwise the dedicated pin, shown as channel code zero.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      neg_use_channel <= 1'b0;
    else
      neg_use_channel <= mux_sel;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      neg_channel <= acc_pkg::NEG_SEL_PIN;
    else if (mux_sel)
      neg_channel <= channel_select;
    else
      neg_channel <= acc_pkg::NEG_SEL_PIN;
  end

  // Disable bits switch the pin buffers off and force the port bits low.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      pos_pin_digital_off <= 1'b0;
    else
      pos_pin_digital_off <= dig_r[acc_pkg::BIT_POS_DIG];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      neg_pin_digital_off <= 1'b0;
    else
      neg_pin_digital_off <= dig_r[acc_pkg::BIT_NEG_DIG];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      pos_pin_in <= 1'b0;
    else
      pos_pin_in <= ps2_r & ~dig_r[acc_pkg::BIT_POS_DIG];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      neg_pin_in <= 1'b0;
    else
      neg_pin_in <= ns2_r & ~dig_r[acc_pkg::BIT_NEG_DIG];
  end

  // Read data stand only in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rdata <= acc_pkg::READ_ZERO;
    else if (!rd)
      rdata <= acc_pkg::READ_ZERO;
    else
    begin
      case (addr)
        acc_pkg::ADDR_CMP_CTRL:
          rdata <= status_byte(ctrl_r, sync2_r, flag_r);
        acc_pkg::ADDR_CONV_CTRL_B:
          rdata <= convb_r;
        acc_pkg::ADDR_DIG_DIS:
          rdata <= dig_r;
        default:
          rdata <= acc_pkg::READ_ZERO;
      endcase
    end
  end
endmodule // acc_top

// ===== acc_analog_model.sv
// Far-side model: analog inputs, pin levels and the comparator core.
module acc_analog_model
#(parameter logic [7:0] BANDGAP_LEVEL = 8'h80)
(
  input  wire logic [7:0] pos_v,
  input  wire logic [7:0] neg_v,
  input  wire logic       pin_hi,
  input  wire logic       bandgap_select,
  output logic            comparator_raw,
  output logic            pos_pin_digital_raw,
  output logic            neg_pin_digital_raw
);
  timeunit 1ns;
  timeprecision 1ns;
  assign comparator_raw = (bandgap_select ? BANDGAP_LEVEL : pos_v) > neg_v;
  assign pos_pin_digital_raw = pin_hi;
  assign neg_pin_digital_raw = pin_hi;
endmodule // acc_analog_model

// ===== acc_top_sva.sv
// Port checker for the comparator control block.
module acc_top_sva
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       converter_enable,
  input wire logic       global_irq_enable,
  input wire logic       vector_taken,
  input wire logic       irq_request,
  input wire logic       neg_use_channel,
  input wire logic [2:0] neg_channel,
  input wire logic       pos_pin_digital_off,
  input wire logic       neg_pin_digital_off,
  input wire logic       pos_pin_in,
  input wire logic       neg_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_chan_pin_zero: assert property (!neg_use_channel |-> !neg_channel)
    else $error("channel shown with pin");
  a_conv_on_pin: assert property (converter_enable &&
    $past(converter_enable) |-> !neg_use_channel) else $error("mux used");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside slot");
  a_unmapped_zero: assert property ($past(rd) && $past(addr) > 8'h32
    |-> rdata == 8'h00) else $error("unmapped read");
  a_pos_dig_off: assert property (pos_pin_digital_off &&
    $past(pos_pin_digital_off) |-> !pos_pin_in) else $error("pos pin");
  a_neg_dig_off: assert property (neg_pin_digital_off &&
    $past(neg_pin_digital_off) |-> !neg_pin_in) else $error("neg pin");
  a_irq_global: assert property (irq_request |->
    $past(global_irq_enable)) else $error("request without global");
  a_irq_vector: assert property (vector_taken |=> !irq_request)
    else $error("request after vector");
endmodule // acc_top_sva

// ===== testbench.sv
// Self-checking bench for the comparator control block.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("BAD %0t mismatch", $time); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, wr = 0, rd = 0, pin_hi = 0;
  logic converter_enable = 0, global_irq_enable = 0, vector_taken = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, pv = 8'h0a, nv = 8'h14;
  logic [2:0] channel_select = 0, neg_channel;
  logic comparator_raw, pos_pin_digital_raw, neg_pin_digital_raw;
  logic irq_request, capture_input, comparator_power_off, bandgap_select;
  logic neg_use_channel, pos_pin_digital_off, neg_pin_digital_off;
  logic pos_pin_in, neg_pin_in, r, f;
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  acc_top u_acc_top (.ref_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .comparator_raw, .converter_enable, .channel_select, .global_irq_enable,
    .vector_taken, .pos_pin_digital_raw, .neg_pin_digital_raw, .irq_request,
    .capture_input, .comparator_power_off, .bandgap_select, .neg_use_channel,
    .neg_channel, .pos_pin_digital_off, .neg_pin_digital_off, .pos_pin_in,
    .neg_pin_in);
  acc_analog_model u_acc_analog_model (.pos_v(pv), .neg_v(nv), .pin_hi,
    .bandgap_select, .comparator_raw, .pos_pin_digital_raw,
    .neg_pin_digital_raw);
  task stop_test;
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task idle(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, d);
    @(posedge ref_clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge ref_clk);
    wr <= 0;
  endtask
  task rd_chk(input logic [7:0] a, e);
    @(posedge ref_clk);
    addr <= a; rd <= 1;
    @(posedge ref_clk);
    rd <= 0;
    #1 `CHK(rdata, e)
  endtask
  task t_ctrl;
    rd_chk(8'h30, 8'h00); rd_chk(8'h33, 8'h00);
    wr_reg(8'h30, 8'hc4); idle(4);
    `CHK({comparator_power_off, bandgap_select}, 2'h3)
    `CHK(capture_input, 1'h1)
    rd_chk(8'h30, 8'hf4);
    wr_reg(8'h30, 8'h00); idle(4);
    `CHK({comparator_power_off, capture_input}, 2'h0)
  endtask
  task t_mux;
    wr_reg(8'h31, 8'h40); channel_select <= 3'h5; idle(3);
    `CHK({neg_use_channel, neg_channel}, 4'hd)
    @(posedge ref_clk) converter_enable <= 1;
    idle(3);
    `CHK(neg_use_channel, 1'h0)
    rd_chk(8'h31, 8'h40);
  endtask
  task t_events;
    for (int i = 0; i < 4; i++)
    begin
      r = (i == 0 || i == 3); f = (i == 0 || i == 2);
      wr_reg(8'h30, 8'h10 | i); global_irq_enable <= i[0];
      wr_reg(8'h30, 8'h08 | i); pv <= 8'h1e; idle(6);
      rd_chk(8'h30, {3'h1, r, 2'h2, i[1:0]});
      `CHK(irq_request, r & i[0])
      wr_reg(8'h30, 8'h18 | i); pv <= 8'h0a; idle(6);
      rd_chk(8'h30, {3'h0, f, 2'h2, i[1:0]});
      @(posedge ref_clk) vector_taken <= 1;
      @(posedge ref_clk) vector_taken <= 0;
      idle(2); rd_chk(8'h30, 8'h08 | i);
    end
  endtask
  task t_dig;
    pin_hi <= 1; wr_reg(8'h32, 8'h03); idle(4);
    `CHK({pos_pin_in, neg_pin_in, pos_pin_digital_off, neg_pin_digital_off}, 4'h3)
    wr_reg(8'h32, 8'h00); idle(4);
    `CHK({pos_pin_in, neg_pin_in}, 2'h3)
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      stop_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1;
    t_ctrl; t_mux; t_events; t_dig;
    stop_test;
  end
endmodule // testbench
bind acc_top acc_top_sva u_acc_top_sva (.ref_clk, .resetn, .addr, .rd,
  .rdata, .converter_enable, .global_irq_enable, .vector_taken, .irq_request,
  .neg_use_channel, .neg_channel, .pos_pin_digital_off, .neg_pin_digital_off,
  .pos_pin_in, .neg_pin_in);
